// ### rtl/lfrs_top.sv
// Lock fault response selector: fault trackers, response arbitration, AXI4-Lite registers
`timescale 1ns/1ps
`include "lfrs_map.svh"
module lfrs_top #(
   parameter int unsigned TICK_CYCLES = `LFRS_TICK_CYCLES
) (
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   input  wire logic [`LFRS_ADDR_W-1:0]  s_axi_awaddr_in,
   input  wire logic [2:0]               s_axi_awprot_in,
   input  wire logic                     s_axi_awvalid_in,
   output logic                          s_axi_awready_out,
   input  wire logic [31:0]              s_axi_wdata_in,
   input  wire logic [3:0]               s_axi_wstrb_in,
   input  wire logic                     s_axi_wvalid_in,
   output logic                          s_axi_wready_out,
   output logic [1:0]                    s_axi_bresp_out,
   output logic                          s_axi_bvalid_out,
   input  wire logic                     s_axi_bready_in,
   input  wire logic [`LFRS_ADDR_W-1:0]  s_axi_araddr_in,
   input  wire logic [2:0]               s_axi_arprot_in,
   input  wire logic                     s_axi_arvalid_in,
   output logic                          s_axi_arready_out,
   output logic [31:0]                   s_axi_rdata_out,
   output logic [1:0]                    s_axi_rresp_out,
   output logic                          s_axi_rvalid_out,
   input  wire logic                     s_axi_rready_in,
   input  wire logic                     motor_stall_detect_in,
   input  wire logic [`LFRS_SENSE_W-1:0] sense_amp_output_in,
   output lfrs_pkg::lfrs_phase_t         phase_ctrl_out,
   output logic                          fault_out_low,
   output logic                          irq_out
);
   import lfrs_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                     aw_free_reg;
   logic                     w_free_reg;
   logic                     ar_free_reg;
   logic                     bvalid_reg;
   logic                     rvalid_reg;
   logic [1:0]               bresp_reg;
   logic [1:0]               rresp_reg;
   logic [31:0]              rdata_reg;
   logic [`LFRS_ADDR_W-1:0]  awaddr_reg;
   logic [31:0]              wdata_reg;
   logic [3:0]               wstrb_reg;
   logic [11:0]              mode_reg;
   logic [11:0]              hw_thr_reg;
   logic [11:0]              sw_thr_reg;
   logic [15:0]              retry_reg;
   logic [2:0]               irq_stat_reg;
   logic [2:0]               irq_mask_reg;
   logic                     clear_reg;
   lfrs_phase_t              phase_reg;
   logic                     fault_low_reg;
   logic                     irq_reg;
   lfrs_state_t              st_vec [`LFRS_NUM_FAULTS];
   lfrs_resp_t               resp   [`LFRS_NUM_FAULTS];
   logic [2:0]               detect;
   logic [2:0]               trip;
   logic [2:0]               entry;
   logic [2:0]               retry_entry;
   logic [2:0]               active;
   logic [2:0]               latched;
   logic                     retry_done;
   logic [1:0]               best_rank;
   lfrs_phase_t              best_act;

   // ----------------------------------------------------------------
   // Fault detection
   // ----------------------------------------------------------------
   // Strict compare: a sense value equal to the threshold does not trip
   assign detect[0] = motor_stall_detect_in;
   assign detect[1] = sense_amp_output_in > hw_thr_reg;
   assign detect[2] = sense_amp_output_in > sw_thr_reg;

   // ----------------------------------------------------------------
   // Per-fault trackers
   // ----------------------------------------------------------------
   for (genvar i = 0; i < `LFRS_NUM_FAULTS; i++) begin : g_fault
      lfrs_state_t st_reg;
      lfrs_state_t st_next;

      // Same code table serves all three faults; 1xx1 disables, 1xx0 reports only
      assign resp[i]        = lfrs_decode(mode_reg[i*`LFRS_MODE_W +: `LFRS_MODE_W]);
      assign trip[i]        = detect[i] & (resp[i].enter != LFRS_ST_IDLE);
      assign entry[i]       = (st_reg == LFRS_ST_IDLE) & trip[i];
      assign retry_entry[i] = entry[i] & (resp[i].enter == LFRS_ST_RETRY);
      assign active[i]      = st_reg != LFRS_ST_IDLE;
      assign latched[i]     = st_reg == LFRS_ST_LATCH;
      assign st_vec[i]      = st_reg;

      // Latched waits for clear, retry for the timer, report follows the condition
      always_comb begin
         st_next = st_reg;
         case (st_reg)
            LFRS_ST_IDLE:   if (trip[i]) st_next = resp[i].enter;
            LFRS_ST_LATCH:  if (clear_reg) st_next = LFRS_ST_IDLE;
            LFRS_ST_RETRY:  if (retry_done) st_next = LFRS_ST_IDLE;
            LFRS_ST_REPORT: if (!trip[i]) st_next = LFRS_ST_IDLE;
            default:        st_next = LFRS_ST_IDLE;
         endcase
         if (resp[i].enter == LFRS_ST_IDLE) begin
            st_next = LFRS_ST_IDLE;
         end
      end

      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) st_reg <= LFRS_ST_IDLE;
         else          st_reg <= st_next;
      end

      a_latch_hold: assert property (
         @(posedge clk_in) disable iff (reset_in)
         (latched[i] && !clear_reg && resp[i].enter != LFRS_ST_IDLE) |=> latched[i])
         else $error("latched fault left without clear");
      a_clear_frees: assert property (
         @(posedge clk_in) disable iff (reset_in)
         (latched[i] && clear_reg) |=> st_reg == LFRS_ST_IDLE)
         else $error("clear did not release latched fault");
      a_disabled_quiet: assert property (
         @(posedge clk_in) disable iff (reset_in)
         (resp[i].enter == LFRS_ST_IDLE) |=> !active[i])
         else $error("disabled fault became active");
      a_latch_entry: assert property (
         @(posedge clk_in) disable iff (reset_in)
         (entry[i] && resp[i].enter == LFRS_ST_LATCH) |=> latched[i])
         else $error("latched code did not latch");
      a_retry_entry: assert property (
         @(posedge clk_in) disable iff (reset_in)
         retry_entry[i] |=> st_reg == LFRS_ST_RETRY)
         else $error("retry code did not enter retry");
   end

   // ----------------------------------------------------------------
   // Retry interval and arbitration
   // ----------------------------------------------------------------
   // One timer for all faults; restarting it on every new retry fault lets the latest one set the wait
   lfrs_retry_timer #(
      .TICK_CYCLES    (TICK_CYCLES)
   ) u_retry (
      .clk_in         (clk_in),
      .reset_in       (reset_in),
      .start_in       (|retry_entry),
      .interval_ms_in (retry_reg),
      .done_out       (retry_done)
   );

   // Highest rank wins; on a tie the lower fault index keeps the stage
   always_comb begin
      best_rank = 2'h0;
      best_act  = LFRS_PH_DRIVE;
      for (int k = 0; k < `LFRS_NUM_FAULTS; k++) begin
         if (lfrs_rank(st_vec[k]) > best_rank) begin
            best_rank = lfrs_rank(st_vec[k]);
            best_act  = (st_vec[k] == LFRS_ST_REPORT) ? LFRS_PH_DRIVE : resp[k].act;
         end
      end
   end

   // Fault pin reacts one cycle after the tracker, well inside the allowed lag
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         phase_reg     <= LFRS_PH_DRIVE;
         fault_low_reg <= 1'b1;
         irq_reg       <= 1'b0;
      end else begin
         phase_reg     <= best_act;
         fault_low_reg <= ~|active;
         irq_reg       <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   wire        do_write = ~aw_free_reg & ~w_free_reg & ~bvalid_reg;
   wire [31:0] wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                           {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire [31:0] wbits    = wdata_reg & wmask;
   wire [7:0]  wr_word  = {awaddr_reg[7:2], 2'b00};
   wire        wsel_ctl = wr_word == `LFRS_OFF_CTRL;
   wire        wsel_mod = wr_word == `LFRS_OFF_MODE;
   wire        wsel_hwt = wr_word == `LFRS_OFF_HW_THR;
   wire        wsel_swt = wr_word == `LFRS_OFF_SW_THR;
   wire        wsel_rty = wr_word == `LFRS_OFF_RETRY;
   wire        wsel_flg = wr_word == `LFRS_OFF_FLAGS;
   wire        wsel_ist = wr_word == `LFRS_OFF_IRQ_STAT;
   wire        wsel_msk = wr_word == `LFRS_OFF_IRQ_MASK;
   wire        wr_hit   = wsel_ctl | wsel_mod | wsel_hwt | wsel_swt |
                          wsel_rty | wsel_flg | wsel_ist | wsel_msk;

   // Byte-lane merge of each writable register
   wire [11:0] mode_next  = (do_write & wsel_mod) ? (mode_reg & ~wmask[11:0]) | wbits[11:0]
                                                  : mode_reg;
   wire [11:0] hw_thr_next = (do_write & wsel_hwt) ? (hw_thr_reg & ~wmask[11:0]) | wbits[11:0]
                                                   : hw_thr_reg;
   wire [11:0] sw_thr_next = (do_write & wsel_swt) ? (sw_thr_reg & ~wmask[11:0]) | wbits[11:0]
                                                   : sw_thr_reg;
   wire [15:0] retry_next = (do_write & wsel_rty) ? (retry_reg & ~wmask[15:0]) | wbits[15:0]
                                                  : retry_reg;
   wire [2:0]  mask_next  = (do_write & wsel_msk) ? (irq_mask_reg & ~wmask[2:0]) | wbits[2:0]
                                                  : irq_mask_reg;
   // New fault entries win over a write-one-to-clear in the same cycle
   wire [2:0]  w1c        = (do_write & wsel_ist) ? wbits[2:0] : 3'h0;
   wire [2:0]  irq_stat_next = (irq_stat_reg & ~w1c) | entry;
   wire        clear_next = do_write & wsel_ctl & wbits[`LFRS_CTRL_CLR_BIT];

   // Address and data are held separately so either may arrive first
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         aw_free_reg <= 1'b1;
         w_free_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `LFRS_RESP_OKAY;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end else begin
         if (aw_free_reg & s_axi_awvalid_in) begin
            aw_free_reg <= 1'b0;
            awaddr_reg  <= s_axi_awaddr_in;
         end
         if (w_free_reg & s_axi_wvalid_in) begin
            w_free_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata_in;
            wstrb_reg  <= s_axi_wstrb_in;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `LFRS_RESP_OKAY : `LFRS_RESP_SLVERR;
         end else if (bvalid_reg & s_axi_bready_in) begin
            bvalid_reg  <= 1'b0;
            aw_free_reg <= 1'b1;
            w_free_reg  <= 1'b1;
         end
      end
   end

   // Configuration stays writable while faults are active; the core never stalls
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         mode_reg     <= `LFRS_MODE_RST;
         hw_thr_reg   <= `LFRS_THR_RST;
         sw_thr_reg   <= `LFRS_THR_RST;
         retry_reg    <= `LFRS_RETRY_RST;
         irq_mask_reg <= `LFRS_BIT3_RST;
         irq_stat_reg <= `LFRS_BIT3_RST;
         clear_reg    <= 1'b0;
      end else begin
         mode_reg     <= mode_next;
         hw_thr_reg   <= hw_thr_next;
         sw_thr_reg   <= sw_thr_next;
         retry_reg    <= retry_next;
         irq_mask_reg <= mask_next;
         irq_stat_reg <= irq_stat_next;
         clear_reg    <= clear_next;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   wire [7:0]  rd_word  = {s_axi_araddr_in[7:2], 2'b00};
   wire [31:0] flags    = {25'h0, |latched, best_act, 1'b0, active};
   wire        rd_hit   = rd_word <= `LFRS_OFF_IRQ_MASK;
   wire [31:0] rd_data  =
      (rd_word == `LFRS_OFF_MODE)     ? {20'h0_0000, mode_reg}   :
      (rd_word == `LFRS_OFF_HW_THR)   ? {20'h0_0000, hw_thr_reg} :
      (rd_word == `LFRS_OFF_SW_THR)   ? {20'h0_0000, sw_thr_reg} :
      (rd_word == `LFRS_OFF_RETRY)    ? {16'h0000, retry_reg}    :
      (rd_word == `LFRS_OFF_FLAGS)    ? flags                    :
      (rd_word == `LFRS_OFF_IRQ_STAT) ? {29'h0, irq_stat_reg}    :
      (rd_word == `LFRS_OFF_IRQ_MASK) ? {29'h0, irq_mask_reg}    : 32'h0000_0000;

   // One read outstanding; address is taken only while no answer is pending
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ar_free_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= `LFRS_RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else if (ar_free_reg & s_axi_arvalid_in) begin
         ar_free_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_data;
         rresp_reg   <= rd_hit ? `LFRS_RESP_OKAY : `LFRS_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready_in) begin
         ar_free_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready_out = aw_free_reg;
   assign s_axi_wready_out  = w_free_reg;
   assign s_axi_bvalid_out  = bvalid_reg;
   assign s_axi_bresp_out   = bresp_reg;
   assign s_axi_arready_out = ar_free_reg;
   assign s_axi_rvalid_out  = rvalid_reg;
   assign s_axi_rresp_out   = rresp_reg;
   assign s_axi_rdata_out   = rdata_reg;
   assign phase_ctrl_out    = phase_reg;
   assign fault_out_low     = fault_low_reg;
   assign irq_out           = irq_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_fault_pin_low: assert property (
      @(posedge clk_in) disable iff (reset_in) (|active) |=> !fault_out_low)
      else $error("active fault not shown on fault pin");
   a_report_drives: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (!(|latched) && !(|retry_entry) && best_rank <= 2'h1) |=> phase_ctrl_out == LFRS_PH_DRIVE)
      else $error("report-only fault changed the stage");
   a_latch_wins: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (st_vec[1] == LFRS_ST_LATCH && st_vec[0] != LFRS_ST_LATCH)
      |=> phase_ctrl_out == $past(resp[1].act))
      else $error("latched fault lost arbitration");
   c_latch_seen: cover property (@(posedge clk_in) disable iff (reset_in) |latched);
   c_retry_done: cover property (@(posedge clk_in) disable iff (reset_in) retry_done);
   c_report_only: cover property (
      @(posedge clk_in) disable iff (reset_in) st_vec[2] == LFRS_ST_REPORT);
endmodule

// ### rtl/lfrs_map.svh
// Register offsets, field positions, reset values and timing counts of the lock fault selector
`ifndef LFRS_MAP_SVH
`define LFRS_MAP_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define LFRS_ADDR_W        8
`define LFRS_NUM_FAULTS    3
`define LFRS_MODE_W        4
`define LFRS_SENSE_W       12
`define LFRS_RETRY_W       16

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LFRS_OFF_CTRL      8'h00
`define LFRS_OFF_MODE      8'h04
`define LFRS_OFF_HW_THR    8'h08
`define LFRS_OFF_SW_THR    8'h0C
`define LFRS_OFF_RETRY     8'h10
`define LFRS_OFF_FLAGS     8'h14
`define LFRS_OFF_IRQ_STAT  8'h18
`define LFRS_OFF_IRQ_MASK  8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LFRS_CTRL_CLR_BIT  0
`define LFRS_FLAGS_PH_LSB  4
`define LFRS_FLAGS_LAT_BIT 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LFRS_MODE_RST      12'h000
`define LFRS_THR_RST       12'hFFF
`define LFRS_RETRY_RST     16'h0064
`define LFRS_BIT3_RST      3'h0

// ----------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------
`define LFRS_RESP_OKAY     2'h0
`define LFRS_RESP_SLVERR   2'h2
`define LFRS_CLK_PERIOD_NS 25
`define LFRS_MS_IN_NS      1000000
`define LFRS_TICK_CYCLES   (`LFRS_MS_IN_NS / `LFRS_CLK_PERIOD_NS)

`endif

// ### rtl/lfrs_pkg.sv
// Types and decode helpers of the lock fault selector
package lfrs_pkg;

   // Fault tracker state; the same codes name the state a mode enters
   typedef enum logic [1:0] {
      LFRS_ST_IDLE   = 2'b00,
      LFRS_ST_LATCH  = 2'b01,
      LFRS_ST_RETRY  = 2'b10,
      LFRS_ST_REPORT = 2'b11
   } lfrs_state_t;

   // Phase stage command
   typedef enum logic [1:0] {
      LFRS_PH_DRIVE = 2'b00,
      LFRS_PH_HIZ   = 2'b01,
      LFRS_PH_HSBRK = 2'b10,
      LFRS_PH_LSBRK = 2'b11
   } lfrs_phase_t;

   // Decoded response of one mode code
   typedef struct packed {
      lfrs_state_t enter;
      lfrs_phase_t act;
   } lfrs_resp_t;

   // Mode code to response; low two bits pick the stage action
   function automatic lfrs_resp_t lfrs_decode(input logic [3:0] code);
      lfrs_resp_t r;
      r.act = code[1] ? (code[0] ? LFRS_PH_LSBRK : LFRS_PH_HSBRK) : LFRS_PH_HIZ;
      casez (code)
         4'b1??1: r.enter = LFRS_ST_IDLE;
         4'b1???: r.enter = LFRS_ST_REPORT;
         4'b01??: r.enter = LFRS_ST_RETRY;
         default: r.enter = LFRS_ST_LATCH;
      endcase
      return r;
   endfunction

   // Rank for multi-fault arbitration: latched > retry > report
   function automatic logic [1:0] lfrs_rank(input lfrs_state_t s);
      case (s)
         LFRS_ST_LATCH:  return 2'h3;
         LFRS_ST_RETRY:  return 2'h2;
         LFRS_ST_REPORT: return 2'h1;
         default:        return 2'h0;
      endcase
   endfunction

endpackage

// ### rtl/lfrs_retry_timer.sv
// Shared retry interval timer with a millisecond enable divider
`timescale 1ns/1ps
`include "lfrs_map.svh"
module lfrs_retry_timer #(
   parameter int unsigned TICK_CYCLES = `LFRS_TICK_CYCLES
) (
   input  wire logic                     clk_in,
   input  wire logic                     reset_in,
   input  wire logic                     start_in,
   input  wire logic [`LFRS_RETRY_W-1:0] interval_ms_in,
   output logic                          done_out
);
   logic                     busy_reg;
   logic                     done_reg;
   logic [31:0]              div_reg;
   logic [`LFRS_RETRY_W-1:0] cnt_reg;
   wire                      tick = busy_reg & (div_reg == TICK_CYCLES - 1);

   // A new start restarts the count, so the latest retry fault sets the wait
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         div_reg  <= 32'h0000_0000;
         cnt_reg  <= 16'h0000;
      end else begin
         done_reg <= 1'b0;
         if (start_in) begin
            busy_reg <= 1'b1;
            div_reg  <= 32'h0000_0000;
            cnt_reg  <= interval_ms_in;
         end else if (tick) begin
            div_reg <= 32'h0000_0000;
            if (cnt_reg <= 16'h0001) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 16'h0001;
            end
         end else if (busy_reg) begin
            div_reg <= div_reg + 32'h0000_0001;
         end
      end
   end

   assign done_out = done_reg;

   a_start_arms: assert property (
      @(posedge clk_in) disable iff (reset_in) start_in |=> busy_reg && !done_reg)
      else $error("retry timer not armed after start");
   a_done_ends: assert property (
      @(posedge clk_in) disable iff (reset_in) done_reg |-> !busy_reg && $past(busy_reg))
      else $error("retry done without a running interval");
endmodule

// ### verification/lfrs_stage_model.sv
// Behavioural three-phase power stage feeding the current sense path
`timescale 1ns/1ps
module lfrs_stage_model
   import lfrs_pkg::*;
(
   input  wire logic [11:0] load_in,
   input  lfrs_phase_t      phase_in,
   output logic      [11:0] sense_out
);
   // A floated bridge lets winding current decay; drive and both brakes keep it flowing
   assign sense_out = (phase_in == LFRS_PH_HIZ) ? 12'h000 : load_in;
endmodule

// ### verification/tb_top.sv
// Self-checking bench of the lock fault response selector
`timescale 1ns/1ps
`include "lfrs_map.svh"
module tb_top;
   import lfrs_pkg::*;
   logic        clk_in, reset_in, awv, wv, brdy, arv, rrdy, stall;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd;
   logic [11:0] load, mode;
   logic [1:0]  rsp, wrsp;
   // Rows: {mode code, expected stage command, expected fault pin}
   logic [6:0]  rows [8] = '{7'h02, 7'h14, 7'h1E, 7'h22, 7'h34, 7'h3E, 7'h40, 7'h49};
   wire logic   awr, wrd, bv, arr, rv, nflt, irq;
   wire logic [31:0] rdo;
   wire logic [1:0]  bre, rre;
   wire logic [11:0] sense;
   lfrs_phase_t ph;
   int          mismatches, total_checks;

   // Short tick so that a 1 ms retry lasts only 4 cycles
   lfrs_top #(.TICK_CYCLES(4)) i_lfrs_top (.clk_in(clk_in), .reset_in(reset_in),
      .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(bre),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy), .s_axi_araddr_in(ara),
      .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdo), .s_axi_rresp_out(rre), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rrdy), .motor_stall_detect_in(stall), .sense_amp_output_in(sense),
      .phase_ctrl_out(ph), .fault_out_low(nflt), .irq_out(irq));
   lfrs_stage_model i_lfrs_stage_model (.load_in(load), .phase_in(ph), .sense_out(sense));

   // 40 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   // Ready is a flop, so its value at the falling edge is what the next rising edge samples
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, pb, ta, tw, tb;
      @(posedge clk_in);
      {pa, pw, pb} = 3'h7;
      awa <= a;
      wd <= d;
      {awv, wv, brdy} <= 3'h7;
      while (pa || pw || pb) begin
         @(negedge clk_in);
         {ta, tw, tb} = {pa & awr, pw & wrd, pb & bv};
         if (tb) wrsp = bre;
         @(posedge clk_in);
         {pa, pw, pb} = {pa & !ta, pw & !tw, pb & !tb};
         {awv, wv, brdy} <= {pa, pw, pb};
      end
   endtask

   task automatic rdreg(input logic [7:0] a);
      logic pa, pr, ta, tr;
      @(posedge clk_in);
      {pa, pr} = 2'h3;
      ara <= a;
      {arv, rrdy} <= 2'h3;
      while (pa || pr) begin
         @(negedge clk_in);
         {ta, tr} = {pa & arr, pr & rv};
         if (tr) {rd, rsp} = {rdo, rre};
         @(posedge clk_in);
         {pa, pr} = {pa & !ta, pr & !tr};
         {arv, rrdy} <= {pa, pr};
      end
   endtask

   // Trip, look at the stage, remove the cause; a latched code must hold until the clear
   task automatic trip_clear(input logic [1:0] ep, input logic ef, input logic lat);
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("phase", ep, ph);
      chk("fault pin", ef, nflt);
      @(posedge clk_in);
      stall <= 1'b0;
      load <= 12'h000;
      repeat (5) @(posedge clk_in);
      @(negedge clk_in);
      chk("phase held", lat ? ep : LFRS_PH_DRIVE, ph);
      wr(`LFRS_OFF_CTRL, 32'h0000_0001);
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      chk("phase", LFRS_PH_DRIVE, ph);
      chk("fault pin", 1, nflt);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence: reset, the eight table codes for every fault, then the awkward cases
   initial begin
      {reset_in, awv, wv, brdy, arv, rrdy, stall} = 7'h40;
      {awa, ara, wd, load} = '0;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      chk("phase", LFRS_PH_DRIVE, ph);
      chk("fault pin", 1, nflt);
      wr(`LFRS_OFF_HW_THR, 32'h0000_0100);
      chk("bresp", `LFRS_RESP_OKAY, wrsp);
      wr(`LFRS_OFF_SW_THR, 32'h0000_0100);
      wr(`LFRS_OFF_RETRY, 32'h0000_0001);
      for (int k = 0; k < 3; k++) begin
         foreach (rows[i]) begin
            mode = 12'h999;
            mode[4*k +: 4] = rows[i][6:3];
            wr(`LFRS_OFF_MODE, {20'h0_0000, mode});
            stall <= (k == 0);
            load <= (k == 0) ? 12'h000 : 12'h200;
            trip_clear(rows[i][2:1], rows[i][0], rows[i][6:5] == 2'b00);
         end
      end
      // Latched float outranks a braking retry and outlives the trip cause
      wr(`LFRS_OFF_MODE, 32'h0000_0609);
      load <= 12'h200;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("phase", LFRS_PH_HIZ, ph);
      repeat (18) @(posedge clk_in);
      rdreg(`LFRS_OFF_FLAGS);
      chk("flags", 32'h0000_0052, rd);
      trip_clear(LFRS_PH_HIZ, 0, 1);
      wr(`LFRS_OFF_IRQ_MASK, 32'h0000_0007);
      @(negedge clk_in);
      chk("irq", 1, irq);
      wr(`LFRS_OFF_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge clk_in);
      rdreg(`LFRS_OFF_IRQ_STAT);
      chk("irq", 0, irq);
      chk("status", 0, rd);
      wr(8'h20, 32'h0000_0001);
      chk("bresp", `LFRS_RESP_SLVERR, wrsp);
      rdreg(8'h20);
      chk("resp", `LFRS_RESP_SLVERR, rsp);
      chk("rdata", 0, rd);
      end_sim;
   end

   // Watchdog well beyond the expected run length
   initial begin
      #125000;
      mismatches++;
      end_sim;
   end
endmodule
